// ---- core/sdpc_pkg.sv ----
package sdpc_pkg;

   localparam int WORD_W = 24;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CNT_W = 5;

   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
   localparam logic [CNT_W-1:0] CNT_SAT = 5'h19;
   localparam logic [CNT_W-1:0] CNT_STEP = 5'h01;

   localparam logic [ADDR_W-1:0] ADDR_NOP = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_READBACK = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h55;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h56;
   localparam logic [ADDR_W-1:0] READBACK_HEAD = 8'h00;

   localparam logic [DATA_W-1:0] CODE_ZERO = 16'h0000;
   localparam logic [DATA_W-1:0] CODE_MID = 16'h8000;
   localparam logic [DATA_W-1:0] SIGN_FLIP = 16'h8000;
   localparam logic [DATA_W-1:0] CODE_NONE = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

   localparam int RB_SEL_BIT = 0;

   localparam int PIN_SCLK = 0;
   localparam int PIN_SERIAL_IN = 1;
   localparam int PIN_LATCH = 2;
   localparam int PIN_CLEAR = 3;
   localparam int PIN_CLRSEL = 4;
   localparam int PIN_HOT = 5;
   localparam int PIN_N = 6;

endpackage : sdpc_pkg

// ---- core/sdpc_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module sdpc_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = 2
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [STAGES-1:0][WIDTH-1:0] stage;

   generate
      if (STAGES < 2)
      begin : g_bad_stages
         $error("sdpc_sync needs at least two stages");
      end
   endgenerate

   // Only the next stage reads a stage; the last one is the output.
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         stage <= '0;
      end
      else
      begin
         stage <= {stage[STAGES-2:0], async_in};
      end
   end

   assign sync_out = stage[STAGES-1];

endmodule : sdpc_sync

`default_nettype wire

// ---- core/sdpc_core.sv ----
// What this block does
// - Capture the serial input level on every rising shift-clock edge.
// - Load strobe rise moves the shifted word into the converter register.
// - In readback or daisy-chain mode, serial output moves on falling edges.
// - While clear is high, the output is forced to the selected clear value.
// - Clear-select level picks zero-scale or mid-scale clear code.
// - Over-temperature pulls the open-drain thermal alert low.
// - Half-scale is 0x8000 straight binary or 0x0000 twos complement.
// - Negative full scale: 0x0000 straight binary, 0x8000 twos complement.
// - Frames are 24 bits, MSB first: 8-bit address then 16-bit data.
// - Decode address: no-op, data, control, reset, and readback request.
`timescale 1ns/1ns
`default_nettype none

module sdpc_core (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic sclk_in,
   input wire logic serial_in_in,
   input wire logic latch_in,
   input wire logic clear_input_in,
   input wire logic clear_level_select_in,
   input wire logic thermal_alert_n_in,
   input wire logic twos_comp_in,
   input wire logic daisy_chain_in,
   output logic [sdpc_pkg::DATA_W-1:0] dac_code_out,
   output logic [sdpc_pkg::DATA_W-1:0] ctrl_reg_out,
   output logic serial_out_out,
   output logic serial_out_oe_out,
   output logic thermal_alert_n_out,
   output logic thermal_alert_n_oe_out
);

   ////////////////////////////////////////////////////////////////////////
   logic [sdpc_pkg::PIN_N-1:0] pins_s;
   logic sclk_d;
   logic latch_d;
   logic sclk_rise;
   logic sclk_fall;
   logic latch_rise;
   logic [sdpc_pkg::WORD_W-1:0] sr;
   logic [sdpc_pkg::CNT_W-1:0] bit_cnt;
   logic [sdpc_pkg::DATA_W-1:0] data_reg;
   logic [sdpc_pkg::DATA_W-1:0] ctrl_reg;
   logic readback_active;
   logic frame_ok;
   logic [sdpc_pkg::ADDR_W-1:0] addr_f;
   logic [sdpc_pkg::DATA_W-1:0] data_f;
   logic rb_load;
   logic [sdpc_pkg::DATA_W-1:0] rb_value;
   logic [sdpc_pkg::DATA_W-1:0] core_code;
   logic [sdpc_pkg::DATA_W-1:0] clear_code;
   logic [sdpc_pkg::DATA_W-1:0] next_code;
   logic sdo_drive;

   // Every pin except twos_comp_in and daisy_chain_in, including the shift clock, is sampled by the system clock.
   sdpc_sync #(
      .WIDTH(sdpc_pkg::PIN_N),
      .STAGES(2)
   ) u_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .async_in({thermal_alert_n_in, clear_level_select_in, clear_input_in,
                 latch_in, serial_in_in, sclk_in}),
      .sync_out(pins_s)
   );

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sclk_d <= 1'b0;
         latch_d <= 1'b0;
      end
      else
      begin
         sclk_d <= pins_s[sdpc_pkg::PIN_SCLK];
         latch_d <= pins_s[sdpc_pkg::PIN_LATCH];
      end
   end

   assign sclk_rise = pins_s[sdpc_pkg::PIN_SCLK] && !sclk_d;
   assign sclk_fall = !pins_s[sdpc_pkg::PIN_SCLK] && sclk_d;
   assign latch_rise = pins_s[sdpc_pkg::PIN_LATCH] && !latch_d;

   ////////////////////////////////////////////////////////////////////////
   assign addr_f = sr[sdpc_pkg::WORD_W-1:sdpc_pkg::DATA_W];
   assign data_f = sr[sdpc_pkg::DATA_W-1:0];
   assign frame_ok = latch_rise && (bit_cnt == sdpc_pkg::FRAME_BITS);
   assign rb_load = frame_ok && (addr_f == sdpc_pkg::ADDR_READBACK);
   assign rb_value = data_f[sdpc_pkg::RB_SEL_BIT] ? ctrl_reg : data_reg;

   // The edge count saturates so that an overlong frame stays invalid.
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         bit_cnt <= '0;
      end
      else if (latch_rise)
      begin
         bit_cnt <= '0;
      end
      else if (sclk_rise && bit_cnt != sdpc_pkg::CNT_SAT)
      begin
         bit_cnt <= bit_cnt + sdpc_pkg::CNT_STEP;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sr <= '0;
      end
      else if (rb_load)
      begin
         sr <= {sdpc_pkg::READBACK_HEAD, rb_value};
      end
      else if (sclk_rise)
      begin
         sr <= {sr[sdpc_pkg::WORD_W-2:0], pins_s[sdpc_pkg::PIN_SERIAL_IN]};
      end
   end

   // Invalid frames fall through every branch and leave the registers.
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         data_reg <= sdpc_pkg::DATA_RESET;
         ctrl_reg <= sdpc_pkg::CTRL_RESET;
      end
      else if (frame_ok)
      begin
         case (addr_f)
            sdpc_pkg::ADDR_DATA: data_reg <= data_f;
            sdpc_pkg::ADDR_CTRL: ctrl_reg <= data_f;
            sdpc_pkg::ADDR_RESET:
            begin
               data_reg <= sdpc_pkg::DATA_RESET;
               ctrl_reg <= sdpc_pkg::CTRL_RESET;
            end
            default:
            begin
               data_reg <= data_reg;
               ctrl_reg <= ctrl_reg;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // The core is offset binary, so twos complement just flips the MSB.
   assign core_code = twos_comp_in ? (data_reg ^ sdpc_pkg::SIGN_FLIP)
                                   : data_reg;
   assign clear_code = pins_s[sdpc_pkg::PIN_CLRSEL] ?
      sdpc_pkg::CODE_MID : sdpc_pkg::CODE_ZERO;
   assign next_code = pins_s[sdpc_pkg::PIN_CLEAR] ? clear_code
                                                  : core_code;

   // Clear is level sensitive and needs no shift-clock edge to act.
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         dac_code_out <= sdpc_pkg::CODE_ZERO;
         ctrl_reg_out <= sdpc_pkg::CTRL_RESET;
      end
      else
      begin
         dac_code_out <= next_code;
         ctrl_reg_out <= ctrl_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // A readback stays armed for exactly one following frame.
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         readback_active <= 1'b0;
      end
      else if (latch_rise)
      begin
         readback_active <= rb_load;
      end
   end

   assign sdo_drive = readback_active || daisy_chain_in;

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         serial_out_out <= 1'b0;
         serial_out_oe_out <= 1'b0;
      end
      else
      begin
         serial_out_oe_out <= sdo_drive || rb_load;
         if (rb_load)
         begin
            serial_out_out <= sdpc_pkg::READBACK_HEAD[sdpc_pkg::ADDR_W-1];
         end
         else if (sclk_fall)
         begin
            serial_out_out <= sr[sdpc_pkg::WORD_W-1];
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         thermal_alert_n_out <= 1'b0;
         thermal_alert_n_oe_out <= 1'b0;
      end
      else
      begin
         thermal_alert_n_out <= 1'b0;
         thermal_alert_n_oe_out <= pins_s[sdpc_pkg::PIN_HOT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_valid_frame;
      latch_rise && (bit_cnt == sdpc_pkg::FRAME_BITS);
   endsequence

   sequence s_bad_frame;
      latch_rise && (bit_cnt != sdpc_pkg::FRAME_BITS);
   endsequence

   chk_shift_capture: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      sclk_rise && !latch_rise |=>
         sr[0] == $past(pins_s[sdpc_pkg::PIN_SERIAL_IN]))
      else $error("serial input bit not captured");

   chk_data_load: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      s_valid_frame ##0 (addr_f == sdpc_pkg::ADDR_DATA) |=>
         data_reg == $past(data_f) ##1
         ($past(pins_s[sdpc_pkg::PIN_CLEAR]) ||
          dac_code_out == $past(core_code)))
      else $error("data word not loaded to output");

   chk_code_map: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !pins_s[sdpc_pkg::PIN_CLEAR] |=>
         dac_code_out == ($past(twos_comp_in) ?
            ($past(data_reg) ^ sdpc_pkg::CODE_MID) : $past(data_reg)))
      else $error("output code mapping wrong");

   chk_neg_full: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      twos_comp_in && data_reg == sdpc_pkg::CODE_MID |->
         core_code == sdpc_pkg::CODE_ZERO)
      else $error("twos complement negative full scale wrong");

   chk_clear_value: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      pins_s[sdpc_pkg::PIN_CLEAR] [*2] |->
         dac_code_out == ($past(pins_s[sdpc_pkg::PIN_CLRSEL]) ?
            sdpc_pkg::CODE_MID : sdpc_pkg::CODE_ZERO))
      else $error("clear value not forced");

   chk_clear_select: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      pins_s[sdpc_pkg::PIN_CLEAR] && !pins_s[sdpc_pkg::PIN_CLRSEL] |=>
         dac_code_out == sdpc_pkg::CODE_ZERO)
      else $error("zero-scale clear not selected");

   chk_sdo_fall: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $changed(serial_out_out) |-> $past(sclk_fall) || $past(rb_load))
      else $error("serial output changed off a falling edge");

   chk_sdo_idle: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !sdo_drive && !rb_load |=> !serial_out_oe_out)
      else $error("serial output driven while idle");

   chk_bad_frame: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      s_bad_frame |=> $stable(data_reg) && $stable(ctrl_reg))
      else $error("invalid frame changed a register");

   chk_nop_frame: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      s_valid_frame ##0 (addr_f == sdpc_pkg::ADDR_NOP) |=>
         $stable(data_reg) && $stable(ctrl_reg) && !readback_active)
      else $error("no-operation frame had an effect");

   chk_alert_low: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      pins_s[sdpc_pkg::PIN_HOT] |=>
         thermal_alert_n_oe_out && !thermal_alert_n_out)
      else $error("thermal alert not pulled low");

endmodule : sdpc_core

`default_nettype wire

// ---- bench/sdpc_host.sv ----
`timescale 1ns/1ns
`default_nettype none

module sdpc_host (
   input wire logic clk_in,
   input wire logic sdo_in,
   output logic sclk_out,
   output logic sdi_out,
   output logic latch_out
);

   initial
   begin
      sclk_out = 1'b0;
      sdi_out = 1'b1;
      latch_out = 1'b0;
   end

   task automatic idle(input int n);
      repeat (n) @(negedge clk_in);
   endtask : idle

   ////////////////////////////////////////////////////////////////////////////
   // The low phase is the longer one, so the echoed bit has settled before
   // it is sampled just ahead of the next rise.
   task automatic send(input logic [24:0] w, input int n,
                       output logic [23:0] rx);
      int i;
      rx = 24'h000000;
      for (i = n - 1; i >= 0; i--)
      begin
         sclk_out = 1'b0;
         sdi_out = w[i];
         idle(5);
         rx = {rx[22:0], sdo_in};
         sclk_out = 1'b1;
         idle(3);
      end
      sclk_out = 1'b0;
      idle(5);
      latch_out = 1'b1;
      idle(4);
      latch_out = 1'b0;
      sdi_out = ~sdi_out;
      idle(4);
   endtask : send

endmodule : sdpc_host

`default_nettype wire

// ---- bench/tb_serial_dac_pin_control.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_serial_dac_pin_control;

   logic clk_in;
   logic resetn_in;
   logic clr;
   logic clr_sel;
   logic hot;
   logic twos;
   logic daisy;
   logic sclk;
   logic sdi;
   logic latch;
   logic [sdpc_pkg::DATA_W-1:0] dac;
   logic [sdpc_pkg::DATA_W-1:0] ctrl;
   logic serial_out;
   logic sdo_oe;
   logic alert;
   logic alert_oe;
   logic [23:0] rx;
   int failures;
   int checked;
   // The alert line has a board pull-up, so it is high when not pulled.
   wire alert_line = alert_oe ? alert : 1'b1;
   // An undriven serial line shows the inverse bit, so a lost enable shows.
   wire sdo_line = sdo_oe ? serial_out : ~serial_out;

   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   sdpc_host u_host (
      .clk_in(clk_in),
      .sdo_in(sdo_line),
      .sclk_out(sclk),
      .sdi_out(sdi),
      .latch_out(latch)
   );

   sdpc_core u_dut (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .sclk_in(sclk),
      .serial_in_in(sdi),
      .latch_in(latch),
      .clear_input_in(clr),
      .clear_level_select_in(clr_sel),
      .thermal_alert_n_in(hot),
      .twos_comp_in(twos),
      .daisy_chain_in(daisy),
      .dac_code_out(dac),
      .ctrl_reg_out(ctrl),
      .serial_out_out(serial_out),
      .serial_out_oe_out(sdo_oe),
      .thermal_alert_n_out(alert),
      .thermal_alert_n_oe_out(alert_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Control pins as one vector: clear, clear select, hot, twos, daisy.
   task automatic set_ctl(input logic [4:0] v);
      {clr, clr_sel, hot, twos, daisy} = v;
   endtask : set_ctl

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      u_host.send({1'b0, a, d}, 24, rx);
   endtask : wr

   initial
   begin
      repeat (60000) @(posedge clk_in);
      failures++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      failures = 0;
      checked = 0;
      resetn_in = 1'b0;
      set_ctl(5'h00);
      repeat (2) @(negedge clk_in);
      resetn_in = 1'b1;
      u_host.idle(4);
      check(dac, 16'h0000);
      check(16'(sdo_oe), 16'h0000);
      check(16'(alert_line), 16'h0001);
      wr(sdpc_pkg::ADDR_DATA, 16'h1234);
      check(dac, 16'h1234);
      wr(sdpc_pkg::ADDR_CTRL, 16'hA5C3);
      check(ctrl, 16'hA5C3);
      wr(sdpc_pkg::ADDR_NOP, 16'hFFFF);
      wr(8'h77, 16'hFFFF);
      check(dac, 16'h1234);
      check(ctrl, 16'hA5C3);
      // Short and long frames; the long one ends in a valid-looking word.
      u_host.send({1'b0, sdpc_pkg::ADDR_DATA, 16'h0BAD}, 23, rx);
      u_host.send({1'b1, sdpc_pkg::ADDR_DATA, 16'h0BAD}, 25, rx);
      check(dac, 16'h1234);
      check(ctrl, 16'hA5C3);
      wr(sdpc_pkg::ADDR_READBACK, 16'h0001);
      check(16'(sdo_oe), 16'h0001);
      wr(sdpc_pkg::ADDR_NOP, 16'h0000);
      check(16'(rx[23:16]), 16'(sdpc_pkg::READBACK_HEAD));
      check(rx[15:0], 16'hA5C3);
      check(16'(sdo_oe), 16'h0000);
      wr(sdpc_pkg::ADDR_READBACK, 16'h0000);
      wr(sdpc_pkg::ADDR_NOP, 16'h0000);
      check(rx[15:0], 16'h1234);
      set_ctl(5'h02);
      u_host.idle(2);
      check(dac, 16'h9234);
      wr(sdpc_pkg::ADDR_DATA, 16'h0000);
      check(dac, 16'h8000);
      wr(sdpc_pkg::ADDR_DATA, 16'h8000);
      check(dac, 16'h0000);
      set_ctl(5'h00);
      u_host.idle(2);
      check(dac, 16'h8000);
      wr(sdpc_pkg::ADDR_DATA, 16'h4321);
      for (int s = 0; s < 2; s++)
      begin
         set_ctl(s[0] ? 5'h18 : 5'h10);
         u_host.idle(6);
         check(dac, s[0] ? 16'h8000 : 16'h0000);
         set_ctl(s[0] ? 5'h08 : 5'h00);
         u_host.idle(6);
         check(dac, 16'h4321);
      end
      set_ctl(5'h01);
      u_host.idle(2);
      check(16'(sdo_oe), 16'h0001);
      wr(8'hC3, 16'hA55A);
      wr(sdpc_pkg::ADDR_NOP, 16'h0000);
      check(16'(rx[23:16]), 16'h00C3);
      check(rx[15:0], 16'hA55A);
      set_ctl(5'h00);
      u_host.idle(2);
      check(16'(sdo_oe), 16'h0000);
      set_ctl(5'h04);
      u_host.idle(6);
      check(16'(alert_line), 16'h0000);
      set_ctl(5'h00);
      u_host.idle(6);
      check(16'(alert_line), 16'h0001);
      wr(sdpc_pkg::ADDR_RESET, 16'h0000);
      check(dac, 16'h0000);
      check(ctrl, 16'h0000);
      summarize();
   end

endmodule : tb_serial_dac_pin_control

`default_nettype wire
